// file: dcps_pkg.sv
// package for the dual-slot card power select block: types, register map, reset values
package dcps_pkg;

  // supply output switch group, one-hot while powered
  typedef struct packed {
    logic ground;  // discharge switch, 0 V
    logic low;     // 3 V switch
    logic high;    // 5 V switch
  } dcps_supply_sw_t;

  // programming output switch group, at most one closed
  typedef struct packed {
    logic ground;  // discharge switch, 0 V
    logic follow;  // tie to the slot's own switched supply
    logic prog;    // 12 V switch
  } dcps_prog_sw_t;

  // all switch settings of one slot
  typedef struct packed {
    dcps_supply_sw_t supply;
    dcps_prog_sw_t prog;
  } dcps_slot_sw_t;

  // select pins of one slot, supply selects active low
  typedef struct packed {
    logic lowRailSelN;
    logic highRailSelN;
    logic [1:0] progVoltageSel;  // {program, follow}
  } dcps_slot_sel_t;

  localparam int DCPS_PROG_BIT = 1;
  localparam int DCPS_FOLLOW_BIT = 0;

  // overcurrent sense / event bit positions
  localparam int DCPS_OC_A_SUPPLY = 0;
  localparam int DCPS_OC_A_PROG = 1;
  localparam int DCPS_OC_B_SUPPLY = 2;
  localparam int DCPS_OC_B_PROG = 3;
  localparam int DCPS_EV_POWER_DOWN = 4;
  localparam int DCPS_EV_WIDTH = 5;

  // register byte offsets
  localparam logic [11:0] DCPS_OFS_STATUS = 12'h000;
  localparam logic [11:0] DCPS_OFS_EVENT = 12'h004;
  localparam logic [11:0] DCPS_OFS_MASK = 12'h008;
  localparam logic [11:0] DCPS_OFS_CONTROL = 12'h00C;

  // control register fields
  localparam int DCPS_CTRL_SOFT_OFF = 0;

  // status register fields
  localparam int DCPS_STAT_A_SW_LSB = 0;   // 6 bits of slot a switches
  localparam int DCPS_STAT_B_SW_LSB = 8;   // 6 bits of slot b switches
  localparam int DCPS_STAT_OC_LSB = 16;    // 4 live overcurrent bits
  localparam int DCPS_STAT_OFF = 20;       // block in low quiescent state

  // reset values
  localparam logic [DCPS_EV_WIDTH-1:0] DCPS_EVENT_RESET = 5'h00;
  localparam logic [DCPS_EV_WIDTH-1:0] DCPS_MASK_RESET = 5'h00;
  localparam logic DCPS_SOFT_OFF_RESET = 1'b0;
  localparam dcps_slot_sw_t DCPS_SW_RESET = 6'h00;

endpackage

// file: dcps_slot_decode.sv
// switch decode for one card slot
`timescale 1ns/1ps
module dcps_slot_decode (
  input wire logic enable,
  input wire dcps_pkg::dcps_slot_sel_t sel,
  output dcps_pkg::dcps_slot_sw_t sw
);
  import dcps_pkg::*;

  // pure decode of the current pins, nothing stored here
  always_comb begin
    sw = '0;
    if (enable) begin
      // supply pair is active low: 01 -> 3 V, 10 -> 5 V, 00 and 11 ground
      unique case ({sel.lowRailSelN, sel.highRailSelN})
        2'b01: sw.supply.low = 1'b1;
        2'b10: sw.supply.high = 1'b1;
        default: sw.supply.ground = 1'b1;
      endcase
      // reserved code leaves every programming switch open so the pin floats
      unique case (sel.progVoltageSel)
        2'b10: sw.prog.prog = 1'b1;
        2'b01: sw.prog.follow = 1'b1;
        2'b00: sw.prog.ground = 1'b1;
        default: sw.prog = '0;
      endcase
    end
  end

endmodule

// file: dcps_power_select.sv
// top of the dual-slot card power select block with its register slave
//
// Overview of operation
// - supply selects of both slots are active low at the device; the controller model takes active-high enables.
// - supply codes 00 and 11 close only the ground switch, 0 V out.
// - programming code program=1, follow=0 closes only the 12 V switch.
// - programming code program=0, follow=1 ties programming output to slot supply.
// - programming code 00 grounds the output; code 11 opens every programming switch.
// - power-down low opens every switch of both slots and enters low quiescent state.
// - one shared active-low overcurrent flag for any output of either slot.
`timescale 1ns/1ps
module dcps_power_select (
  input wire logic clock,
  input wire logic rst,
  input wire logic powerDownN,
  input wire dcps_pkg::dcps_slot_sel_t slotASel,
  input wire dcps_pkg::dcps_slot_sel_t slotBSel,
  input wire logic [3:0] overcurrentSense,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output dcps_pkg::dcps_slot_sw_t slotASw,
  output dcps_pkg::dcps_slot_sw_t slotBSw,
  output logic overcurrentFlagN,
  output logic quiescent,
  output logic irq,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata
);
  import dcps_pkg::*;

  // register state
  logic softOff;
  logic [DCPS_EV_WIDTH-1:0] eventStatus;
  logic [DCPS_EV_WIDTH-1:0] eventMask;
  logic [3:0] ocPrev;
  logic offPrev;
  logic [DCPS_EV_WIDTH-1:0] eventReadSnap;

  // decode and bus helpers, all combinational
  logic switchesOn;
  logic [DCPS_EV_WIDTH-1:0] eventSet;
  logic accessStart;
  logic accessDone;
  logic mapped;
  logic [31:0] readValue;
  dcps_slot_sw_t next_slotASw;
  dcps_slot_sw_t next_slotBSw;

  // address decode for the error response
  function automatic logic isMapped(input logic [11:0] addr);
    isMapped = (addr == DCPS_OFS_STATUS) || (addr == DCPS_OFS_EVENT) ||
               (addr == DCPS_OFS_MASK) || (addr == DCPS_OFS_CONTROL);
  endfunction

  // the one read that clears events; snapshot and clear must agree on it
  function automatic logic isEventRead(input logic writeDir, input logic [11:0] addr);
    isEventRead = !writeDir && (addr == DCPS_OFS_EVENT);
  endfunction

  // software can force the same off state as the pin, never override it
  assign switchesOn = powerDownN & ~softOff;

  // one decoder per slot; both see the same enable so shutdown is common
  dcps_slot_decode slotADecode (
    .enable(switchesOn),
    .sel(slotASel),
    .sw(next_slotASw)
  );

  dcps_slot_decode slotBDecode (
    .enable(switchesOn),
    .sel(slotBSel),
    .sw(next_slotBSw)
  );

  // switch drives registered once so every output comes from a flop;
  // cost is one clock of lag, far below any analog switching time
  always_ff @(posedge clock) begin
    if (rst) begin
      slotASw <= DCPS_SW_RESET;
      slotBSw <= DCPS_SW_RESET;
    end else begin
      slotASw <= next_slotASw;
      slotBSw <= next_slotBSw;
    end
  end

  // low quiescent indication follows the same enable as the switches,
  // so it never disagrees with the switch outputs by a cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      quiescent <= 1'b0;
    end else begin
      quiescent <= ~switchesOn;
    end
  end

  // shared flag is low while any output limits current
  // it follows the sense lines even with switches open, so a stuck limit stays visible
  always_ff @(posedge clock) begin
    if (rst) begin
      overcurrentFlagN <= 1'b1;
    end else begin
      overcurrentFlagN <= ~(|overcurrentSense);
    end
  end

  // edge history for event detection
  // offPrev resets low so a pin already low at reset release still logs an off event
  always_ff @(posedge clock) begin
    if (rst) begin
      ocPrev <= 4'h0;
      offPrev <= 1'b0;
    end else begin
      ocPrev <= overcurrentSense;
      offPrev <= ~switchesOn;
    end
  end

  // new overcurrent on any output, and entry into the off state
  // a lasting overcurrent raises its event once; live levels are in status
  assign eventSet = {~switchesOn & ~offPrev, overcurrentSense & ~ocPrev};

  // apb handshake: one wait state, answer on the second access cycle
  assign accessStart = psel & penable & ~pready;
  assign accessDone = psel & penable & pready;
  assign mapped = isMapped(paddr);

  // read mux; reserved bits read zero
  // status shows the registered switches, i.e. what the outputs drive now
  always_comb begin
    readValue = 32'h0000_0000;
    unique case (paddr)
      DCPS_OFS_STATUS: begin
        readValue[DCPS_STAT_A_SW_LSB +: 6] = slotASw;
        readValue[DCPS_STAT_B_SW_LSB +: 6] = slotBSw;
        readValue[DCPS_STAT_OC_LSB +: 4] = overcurrentSense;
        readValue[DCPS_STAT_OFF] = quiescent;
      end
      DCPS_OFS_EVENT: readValue[DCPS_EV_WIDTH-1:0] = eventStatus;
      DCPS_OFS_MASK: readValue[DCPS_EV_WIDTH-1:0] = eventMask;
      DCPS_OFS_CONTROL: readValue[DCPS_CTRL_SOFT_OFF] = softOff;
      default: readValue = 32'h0000_0000;
    endcase
  end

  // ready and error are set up in the first access cycle, so the
  // access phase is always exactly two cycles long
  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= accessStart;
      pslverr <= accessStart & ~mapped;
    end
  end

  // read data captured at the same edge and held until the next read
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (accessStart && !pwrite) begin
      prdata <= readValue;
    end
  end

  // remember exactly which event bits the reader was shown
  always_ff @(posedge clock) begin
    if (rst) begin
      eventReadSnap <= DCPS_EVENT_RESET;
    end else if (accessStart) begin
      eventReadSnap <= isEventRead(pwrite, paddr) ? eventStatus : DCPS_EVENT_RESET;
    end
  end

  // sticky events; read clears only bits already returned, so a bit
  // raised during the read survives, and a fresh set beats the clear
  always_ff @(posedge clock) begin
    if (rst) begin
      eventStatus <= DCPS_EVENT_RESET;
    end else if (accessDone && isEventRead(pwrite, paddr)) begin
      eventStatus <= (eventStatus & ~eventReadSnap) | eventSet;
    end else begin
      eventStatus <= eventStatus | eventSet;
    end
  end

  // interrupt mask, written at the completing edge only
  always_ff @(posedge clock) begin
    if (rst) begin
      eventMask <= DCPS_MASK_RESET;
    end else if (accessDone && pwrite && paddr == DCPS_OFS_MASK) begin
      eventMask <= pwdata[DCPS_EV_WIDTH-1:0];
    end
  end

  // soft off acts like the pin going low; it cannot undo a low pin
  // and takes effect at the completing edge only
  always_ff @(posedge clock) begin
    if (rst) begin
      softOff <= DCPS_SOFT_OFF_RESET;
    end else if (accessDone && pwrite && paddr == DCPS_OFS_CONTROL) begin
      softOff <= pwdata[DCPS_CTRL_SOFT_OFF];
    end
  end

  // level interrupt, lags the status register by one clock
  // masked events still stick, so unmasking later raises the line at once
  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(eventStatus & eventMask);
    end
  end

endmodule

// file: dcps_power_select_assertions.sv
// checker for the card power select switch decode
`timescale 1ns/1ps
module dcps_power_select_assertions (
  input wire logic clock,
  input wire logic rst,
  input wire logic powerDownN,
  input wire dcps_pkg::dcps_slot_sel_t slotASel,
  input wire dcps_pkg::dcps_slot_sel_t slotBSel,
  input wire logic [3:0] overcurrentSense,
  input wire dcps_pkg::dcps_slot_sw_t slotASw,
  input wire dcps_pkg::dcps_slot_sw_t slotBSw,
  input wire logic overcurrentFlagN,
  input wire logic quiescent
);
  import dcps_pkg::*;
  logic rstDly;
  // the edge that releases reset still shows reset values, so it is skipped too
  always_ff @(posedge clock) begin
    rstDly <= rst;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || rstDly);
  // soft off shows up as quiescent, so it excuses the decode checks
  AST_A3V: assert property (powerDownN && slotASel[3:2] == 2'b01 |=> quiescent || slotASw.supply == 3'b010)
    else $error("slot a 3 V decode wrong");
  AST_A5V: assert property (powerDownN && slotASel[3:2] == 2'b10 |=> quiescent || slotASw.supply == 3'b001)
    else $error("slot a 5 V decode wrong");
  AST_AGND: assert property (powerDownN && slotASel[3] == slotASel[2] |=> quiescent || slotASw.supply == 3'b100)
    else $error("slot a ground decode wrong");
  AST_B12V: assert property (powerDownN && slotBSel[1:0] == 2'b10 |=> quiescent || slotBSw.prog == 3'b001)
    else $error("slot b 12 V decode wrong");
  AST_BFOL: assert property (powerDownN && slotBSel[1:0] == 2'b01 |=> quiescent || slotBSw.prog == 3'b010)
    else $error("slot b follow decode wrong");
  AST_BHIZ: assert property (slotBSel[1:0] == 2'b11 |=> slotBSw.prog == 3'b000)
    else $error("slot b reserved code not open");
  AST_OFF: assert property (!powerDownN |=> quiescent && slotASw == 6'h00 && slotBSw == 6'h00)
    else $error("power down left a switch closed");
  AST_OC: assert property (!$past(rst) |-> overcurrentFlagN == ($past(overcurrentSense) == 4'h0))
    else $error("overcurrent flag wrong");
  AST_ONE: assert property ($onehot0(slotASw.supply) && $onehot0(slotBSw.prog))
    else $error("two switches of a group closed");
  AST_AGNDP: assert property (powerDownN && slotASel[1:0] == 2'b00 |=> quiescent || slotASw.prog == 3'b100)
    else $error("slot a programming ground decode wrong");
  AST_B3V: assert property (powerDownN && slotBSel[3:2] == 2'b01 |=> quiescent || slotBSw.supply == 3'b010)
    else $error("slot b 3 V decode wrong");
  AST_ONEB: assert property ($onehot0(slotBSw.supply) && $onehot0(slotASw.prog))
    else $error("two switches of another group closed");
endmodule

// file: dcps_slot_ctrl_model.sv
// active-high slot controller feeding the select pins
`timescale 1ns/1ps
module dcps_slot_ctrl_model (
  input wire logic en3,
  input wire logic en5,
  input wire logic [1:0] vpp,
  output dcps_pkg::dcps_slot_sel_t sel
);
  import dcps_pkg::*;
  // lines swapped, so no inverter is needed on the board
  assign sel = {en5, en3, vpp};
endmodule

// file: tb_dual_slot_card_power_select.sv
// testbench for the card power select block
`timescale 1ns/1ps
module tb_dual_slot_card_power_select;
  import dcps_pkg::*;
  typedef struct packed {logic p; logic [3:0] a, b, s; logic [5:0] xa, xb; logic f;} dcps_row_t;
  logic clock = 0, rst = 1, powerDownN = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [3:0] ca = 0, cb = 0, sense = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, prdata;
  dcps_slot_sel_t selA, selB;
  dcps_slot_sw_t swA, swB;
  logic flagN, quiescent, irq, pready, pslverr;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  // {power, ctrl a, ctrl b, sense, switches a, switches b, flag}
  dcps_row_t rows [4] = '{'{1, 4'h8, 4'h6, 4'h0, 6'h14, 6'h09, 1},
    '{1, 4'h1, 4'hF, 4'h1, 6'h22, 6'h20, 0}, '{0, 4'h8, 4'h6, 4'h8, 6'h00, 6'h00, 0},
    '{1, 4'h7, 4'h9, 4'h0, 6'h08, 6'h12, 1}};
  dcps_slot_ctrl_model u_dcps_slot_ctrl_model_a (.en3(ca[3]), .en5(ca[2]), .vpp(ca[1:0]), .sel(selA));
  dcps_slot_ctrl_model u_dcps_slot_ctrl_model_b (.en3(cb[3]), .en5(cb[2]), .vpp(cb[1:0]), .sel(selB));
  dcps_power_select u_dcps_power_select (.clock(clock), .rst(rst), .powerDownN(powerDownN),
    .slotASel(selA), .slotBSel(selB), .overcurrentSense(sense), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .slotASw(swA), .slotBSw(swB),
    .overcurrentFlagN(flagN), .quiescent(quiescent), .irq(irq), .pready(pready),
    .pslverr(pslverr), .prdata(prdata));
  always #2 clock = ~clock;
  // the whole run needs well under 200 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // one transfer; the leading edge keeps psel from being driven twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 0;
    #1 chk("reset outputs", {swA, swB, flagN, irq, quiescent}, 15'h0004);
    apb(0, DCPS_OFS_MASK, 0);
    chk("mask reset", rd, 32'h0);
    foreach (rows[i]) begin
      @(posedge clock);
      powerDownN <= rows[i].p;
      ca <= rows[i].a;
      cb <= rows[i].b;
      sense <= rows[i].s;
      settle(2);
      chk("slot a", swA, rows[i].xa);
      chk("slot b", swB, rows[i].xb);
      chk("flag", flagN, rows[i].f);
      chk("quiet", quiescent, !rows[i].p);
    end
    apb(1, DCPS_OFS_CONTROL, 32'h1);
    settle(2);
    chk("soft off", {quiescent, swA}, 7'h40);
    apb(1, DCPS_OFS_CONTROL, 0);
    apb(0, DCPS_OFS_EVENT, 0);
    apb(1, DCPS_OFS_MASK, 32'h1);
    sense <= 4'h2;
    settle(3);
    chk("masked irq", irq, 0);
    @(posedge clock);
    sense <= 4'h3;
    settle(3);
    chk("irq", irq, 1);
    apb(0, DCPS_OFS_EVENT, 0);
    chk("events", rd, 32'h3);
    settle(2);
    chk("irq cleared", irq, 0);
    apb(0, 12'h010, 0);
    chk("unmapped err", err, 1);
    chk("unmapped data", rd, 0);
    // reset in mid-run with live inputs: outputs return to reset values, then decode again
    @(posedge clock);
    rst <= 1;
    repeat (2) @(posedge clock);
    rst <= 0;
    #1 chk("mid-run reset", {swA, swB, flagN, irq, quiescent}, 15'h0004);
    settle(2);
    chk("decode after reset", {swA, flagN}, 7'h10);
    stop_test();
  end
endmodule
bind dcps_power_select dcps_power_select_assertions u_dcps_power_select_assertions (.clock(clock), .rst(rst),
  .powerDownN(powerDownN), .slotASel(slotASel), .slotBSel(slotBSel), .overcurrentSense(overcurrentSense),
  .slotASw(slotASw), .slotBSw(slotBSw), .overcurrentFlagN(overcurrentFlagN), .quiescent(quiescent));
